// [clru_pkg.sv]
// constants and types of the compare, logic and rotate unit
//
// How it works
// - word register compare subtracts source from destination; 3/3 binary, 2/2 source
// - dword register compare: 3 bytes 5 states binary, 2 bytes 4 states source
// - dword compare with zero-extended 16-bit immediate: 6 states binary, 5 source
// - one-extended immediate fills upper 16 bits with ones; same cost
// - word register versus 16-bit immediate: 5 bytes 4 states, 4 bytes 3 states
// - byte register versus memory through dword pointer: 4 states binary, 3 source
// - word register versus 16-bit direct address: 4/3 states, 5/4 bytes
// - byte operand in external memory adds wait states plus two
// - word operand in external memory adds twice the sum of wait states and two
// - short direct byte source adds 1 state for port, 2 for peripheral register
// - short direct logic destination adds 2 for port, 3 for peripheral register
// - word register logic writes destination; 3 states binary, 2 source
// - accumulator into short direct destination: 2 bytes, 2 states both modes
// - 8-bit immediate into short direct destination: 3 bytes, 3 states both modes
// - word register logic with 16-bit immediate: 4 states binary, 3 source
// - accumulator logic through 8-bit pointer: 2 states binary, 3 source
// - byte register logic: 2 states 3 bytes binary, 1 state 2 bytes source
// - byte register logic from dword pointer memory: 4 states binary, 3 source
// - rotate left one place in 1 state; carry form goes through carry flag
// - rotate right one place in 1 state; carry form goes through carry flag
package clru_pkg;

  // ==========================================================
  // operations, operand forms, widths, operand locations, sequencer states
  typedef enum logic [3:0] {
    COMPARE_OP = 4'h0,
    BITWISE_AND_OP = 4'h1,
    BITWISE_OR_OP = 4'h2,
    BITWISE_XOR_OP = 4'h3,
    CLEAR_ACCUMULATOR_OP = 4'h4,
    INVERT_ACCUMULATOR_OP = 4'h5,
    ROTATE_LEFT_OP = 4'h6,
    ROTATE_LEFT_CARRY_OP = 4'h7,
    ROTATE_RIGHT_OP = 4'h8,
    ROTATE_RIGHT_CARRY_OP = 4'h9
  } clru_op_t;

  typedef enum logic [3:0] {
    FORM_REG_REG = 4'h0,
    FORM_REG_IMM = 4'h1,
    FORM_REG_SHORT_DIR = 4'h2,
    FORM_REG_LONG_DIR = 4'h3,
    FORM_REG_WORD_PTR = 4'h4,
    FORM_REG_DWORD_PTR = 4'h5,
    FORM_ACCUM_REG = 4'h6,
    FORM_ACCUM_SHORT_DIR = 4'h7,
    FORM_ACCUM_PTR = 4'h8,
    FORM_ACCUM_IMM = 4'h9,
    FORM_SHORT_DIR_ACCUM = 4'hA,
    FORM_SHORT_DIR_IMM = 4'hB,
    FORM_ACCUM_ONLY = 4'hC
  } clru_form_t;

  typedef enum logic [1:0] {
    WIDTH_BYTE = 2'h0,
    WIDTH_WORD = 2'h1,
    WIDTH_DWORD = 2'h2
  } clru_width_t;

  typedef enum logic [1:0] {
    LOC_INTERNAL = 2'h0,
    LOC_PORT = 2'h1,
    LOC_PERIPHERAL = 2'h2,
    LOC_EXTERNAL = 2'h3
  } clru_loc_t;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'h1,
    FSM_RUN = 2'h2
  } clru_fsm_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    clru_op_t op;
    clru_form_t form;
    clru_width_t width;
    logic srcMode;
    logic onesExt;
    clru_loc_t loc;
    logic [3:0] waitN;
    logic carryIn;
    logic [31:0] dst;
    logic [31:0] src;
  } clru_cmd_t;

  typedef struct packed {
    logic carryFlag;
    logic zero;
    logic negative;
  } clru_flags_t;

  // ==========================================================
  // cost table, per form and width:
  // {binary bytes, binary states, source bytes, source states}
  localparam int NUM_FORMS = 13;
  localparam logic [15:0] COST_TBL [0:12][0:2] = '{
    '{16'h3221, 16'h3322, 16'h3524},
    '{16'h4332, 16'h5443, 16'h5645},
    '{16'h4332, 16'h4433, 16'h0000},
    '{16'h5342, 16'h5443, 16'h0000},
    '{16'h4332, 16'h0000, 16'h0000},
    '{16'h4433, 16'h0000, 16'h0000},
    '{16'h1122, 16'h0000, 16'h0000},
    '{16'h2121, 16'h0000, 16'h0000},
    '{16'h1223, 16'h0000, 16'h0000},
    '{16'h2121, 16'h0000, 16'h0000},
    '{16'h2222, 16'h0000, 16'h0000},
    '{16'h3333, 16'h0000, 16'h0000},
    '{16'h1111, 16'h0000, 16'h0000}
  };

  // extra states
  localparam logic [7:0] PORT_SRC_EXTRA = 8'h01;
  localparam logic [7:0] SFR_SRC_EXTRA = 8'h02;
  localparam logic [7:0] PORT_DST_EXTRA = 8'h02;
  localparam logic [7:0] SFR_DST_EXTRA = 8'h03;
  localparam logic [7:0] EXT_BASE_EXTRA = 8'h02;

  localparam logic [15:0] ONES_HALF = 16'hFFFF;
  localparam logic [7:0] MIN_STATES = 8'h01;

endpackage

// [clru_cost.sv]
// state and byte cost of one instruction
`timescale 1ns/10ps
module clru_cost (
  input clru_pkg::clru_cmd_t cmd,
  output logic [7:0] states,
  output logic [2:0] bytes
);

  logic [15:0] entry;
  logic [7:0] base;
  logic [7:0] extNorm;
  logic [7:0] extra;

  // ==========================================================
  // table lookup
  always_comb begin
    entry = 16'h0000;
    if (cmd.form <= clru_pkg::FORM_ACCUM_ONLY && cmd.width != 2'h3) begin
      entry = clru_pkg::COST_TBL[cmd.form][cmd.width];
    end
    if (cmd.srcMode) begin
      base = {4'h0, entry[3:0]};
      bytes = entry[6:4];
    end else begin
      base = {4'h0, entry[11:8]};
      bytes = entry[14:12];
    end
  end

  // ==========================================================
  // location penalties
  always_comb begin
    extNorm = {4'h0, cmd.waitN} + clru_pkg::EXT_BASE_EXTRA;
    extra = 8'h00;
    case (cmd.form)
      clru_pkg::FORM_REG_SHORT_DIR, clru_pkg::FORM_ACCUM_SHORT_DIR: begin
        // word form carries no port or peripheral penalty
        if (cmd.width == clru_pkg::WIDTH_BYTE) begin
          if (cmd.loc == clru_pkg::LOC_PORT) begin
            extra = clru_pkg::PORT_SRC_EXTRA;
          end else if (cmd.loc == clru_pkg::LOC_PERIPHERAL) begin
            extra = clru_pkg::SFR_SRC_EXTRA;
          end
        end
      end
      clru_pkg::FORM_SHORT_DIR_ACCUM, clru_pkg::FORM_SHORT_DIR_IMM: begin
        if (cmd.loc == clru_pkg::LOC_PORT) begin
          extra = clru_pkg::PORT_DST_EXTRA;
        end else if (cmd.loc == clru_pkg::LOC_PERIPHERAL) begin
          extra = clru_pkg::SFR_DST_EXTRA;
        end
      end
      clru_pkg::FORM_REG_LONG_DIR, clru_pkg::FORM_REG_WORD_PTR,
      clru_pkg::FORM_REG_DWORD_PTR: begin
        if (cmd.loc == clru_pkg::LOC_EXTERNAL) begin
          if (cmd.width == clru_pkg::WIDTH_WORD) begin
            extra = {extNorm[6:0], 1'b0};
          end else begin
            extra = extNorm;
          end
        end
      end
      default: begin
        extra = 8'h00;
      end
    endcase
    // an unlisted form still costs one state so the sequencer never stalls
    if (base == 8'h00) begin
      states = clru_pkg::MIN_STATES;
    end else begin
      states = base + extra;
    end
  end

endmodule

// [clru_unit.sv]
// compare, bitwise logic, accumulator clear/invert and rotate unit
`timescale 1ns/10ps
module clru_unit (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input clru_pkg::clru_cmd_t cmd,
  output logic busy,
  output logic done,
  output logic wrEn,
  output logic [31:0] result,
  output clru_pkg::clru_flags_t flags,
  output logic [7:0] stateCount,
  output logic [2:0] byteCount
);

  typedef struct packed {
    clru_pkg::clru_fsm_t fsm;
    logic busy;
    logic done;
    logic wrEn;
    logic [31:0] result;
    clru_pkg::clru_flags_t flags;
    logic [7:0] cnt;
    logic [7:0] states;
    logic [2:0] bytes;
    clru_pkg::clru_cmd_t cmd;
  } clru_state_t;

  clru_state_t st_q;
  clru_state_t st_d;
  logic [7:0] costStates;
  logic [2:0] costBytes;
  logic accept;

  // ==========================================================
  // cost of the command offered on the port
  clru_cost u_cost (
    .cmd(cmd),
    .states(costStates),
    .bytes(costBytes)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] widthMask(input clru_pkg::clru_width_t w);
    case (w)
      clru_pkg::WIDTH_BYTE: widthMask = 32'h000000FF;
      clru_pkg::WIDTH_WORD: widthMask = 32'h0000FFFF;
      default: widthMask = 32'hFFFFFFFF;
    endcase
  endfunction

  function automatic logic topBit(input logic [31:0] v,
                                  input clru_pkg::clru_width_t w);
    case (w)
      clru_pkg::WIDTH_BYTE: topBit = v[7];
      clru_pkg::WIDTH_WORD: topBit = v[15];
      default: topBit = v[31];
    endcase
  endfunction

  // source operand after immediate extension
  function automatic logic [31:0] srcOperand(input clru_pkg::clru_cmd_t c);
    srcOperand = c.src;
    if (c.form == clru_pkg::FORM_REG_IMM &&
        c.width == clru_pkg::WIDTH_DWORD) begin
      if (c.onesExt) begin
        srcOperand = {clru_pkg::ONES_HALF, c.src[15:0]};
      end else begin
        srcOperand = {16'h0000, c.src[15:0]};
      end
    end
  endfunction

  assign accept = start && st_q.fsm == clru_pkg::FSM_IDLE;

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] mask;
    logic [31:0] dm;
    logic [31:0] sm;
    logic [32:0] diff;
    logic [7:0] a;
    logic [31:0] res;
    mask = widthMask(st_q.cmd.width);
    dm = st_q.cmd.dst & mask;
    sm = srcOperand(st_q.cmd) & mask;
    diff = {1'b0, dm} - {1'b0, sm};
    a = st_q.cmd.dst[7:0];
    res = 32'h00000000;
    st_d = st_q;
    st_d.done = 1'b0;
    case (st_q.fsm)
      clru_pkg::FSM_IDLE: begin
        st_d.wrEn = 1'b0;
        if (accept) begin
          st_d.fsm = clru_pkg::FSM_RUN;
          st_d.busy = 1'b1;
          st_d.cmd = cmd;
          st_d.states = costStates;
          st_d.bytes = costBytes;
          st_d.cnt = costStates - 8'h01;
        end
      end
      clru_pkg::FSM_RUN: begin
        if (st_q.cnt != 8'h00) begin
          st_d.cnt = st_q.cnt - 8'h01;
        end else begin
          st_d.fsm = clru_pkg::FSM_IDLE;
          st_d.busy = 1'b0;
          st_d.done = 1'b1;
          st_d.wrEn = 1'b1;
          st_d.flags.carryFlag = st_q.cmd.carryIn;
          case (st_q.cmd.op)
            clru_pkg::COMPARE_OP: begin
              // operands are left untouched, only the flags move
              res = st_q.cmd.dst;
              st_d.wrEn = 1'b0;
              st_d.flags.carryFlag = dm < sm;
              diff = diff & {1'b0, mask};
              st_d.flags.zero = diff[31:0] == 32'h00000000;
              st_d.flags.negative = topBit(diff[31:0], st_q.cmd.width);
            end
            clru_pkg::BITWISE_AND_OP: begin
              res = dm & sm;
            end
            clru_pkg::BITWISE_OR_OP: begin
              res = dm | sm;
            end
            clru_pkg::BITWISE_XOR_OP: begin
              res = dm ^ sm;
            end
            clru_pkg::CLEAR_ACCUMULATOR_OP: begin
              res = 32'h00000000;
            end
            clru_pkg::INVERT_ACCUMULATOR_OP: begin
              res = {24'h000000, ~a};
            end
            clru_pkg::ROTATE_LEFT_OP: begin
              res = {24'h000000, a[6:0], a[7]};
            end
            clru_pkg::ROTATE_LEFT_CARRY_OP: begin
              res = {24'h000000, a[6:0], st_q.cmd.carryIn};
              st_d.flags.carryFlag = a[7];
            end
            clru_pkg::ROTATE_RIGHT_OP: begin
              res = {24'h000000, a[0], a[7:1]};
            end
            clru_pkg::ROTATE_RIGHT_CARRY_OP: begin
              res = {24'h000000, st_q.cmd.carryIn, a[7:1]};
              st_d.flags.carryFlag = a[0];
            end
            default: begin
              res = st_q.cmd.dst;
              st_d.wrEn = 1'b0;
            end
          endcase
          if (st_q.cmd.op != clru_pkg::COMPARE_OP) begin
            st_d.flags.zero = (res & mask) == 32'h00000000;
            st_d.flags.negative = topBit(res, st_q.cmd.width);
          end
          st_d.result = res;
        end
      end
      default: begin
        st_d.fsm = clru_pkg::FSM_IDLE;
        st_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.fsm <= clru_pkg::FSM_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign busy = st_q.busy;
  assign done = st_q.done;
  assign wrEn = st_q.wrEn;
  assign result = st_q.result;
  assign flags = st_q.flags;
  assign stateCount = st_q.states;
  assign byteCount = st_q.bytes;

  // ==========================================================
  // checks
  a_word_cmp_bin: assert property (@(posedge mclk) disable iff (!reset_n)
    accept && cmd.op == clru_pkg::COMPARE_OP &&
    cmd.form == clru_pkg::FORM_REG_REG &&
    cmd.width == clru_pkg::WIDTH_WORD && !cmd.srcMode
    |-> ##1 busy[*3] ##1 done && byteCount == 3'h3)
    else $error("word compare binary cost wrong");

  a_dword_cmp_src: assert property (@(posedge mclk) disable iff (!reset_n)
    accept && cmd.op == clru_pkg::COMPARE_OP &&
    cmd.form == clru_pkg::FORM_REG_REG &&
    cmd.width == clru_pkg::WIDTH_DWORD && cmd.srcMode
    |-> ##1 !done[*4] ##1 done && byteCount == 3'h2)
    else $error("dword compare source cost wrong");

  a_zero_ext_cost: assert property (@(posedge mclk) disable iff (!reset_n)
    accept && cmd.form == clru_pkg::FORM_REG_IMM &&
    cmd.width == clru_pkg::WIDTH_DWORD && !cmd.srcMode
    |-> ##7 done)
    else $error("dword immediate binary cost wrong");

  a_ones_ext_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    done && st_q.cmd.op == clru_pkg::COMPARE_OP &&
    st_q.cmd.form == clru_pkg::FORM_REG_IMM &&
    st_q.cmd.width == clru_pkg::WIDTH_DWORD && st_q.cmd.onesExt
    |-> flags.zero == (st_q.cmd.dst == {16'hFFFF, st_q.cmd.src[15:0]}))
    else $error("one-extended immediate compare wrong");

  a_ext_byte_pen: assert property (@(posedge mclk) disable iff (!reset_n)
    accept && cmd.form == clru_pkg::FORM_REG_DWORD_PTR &&
    cmd.width == clru_pkg::WIDTH_BYTE && !cmd.srcMode &&
    cmd.loc == clru_pkg::LOC_EXTERNAL && cmd.waitN == 4'h1
    |-> ##8 done && stateCount == 8'h07)
    else $error("external byte penalty wrong");

  a_ext_word_pen: assert property (@(posedge mclk) disable iff (!reset_n)
    accept && cmd.form == clru_pkg::FORM_REG_LONG_DIR &&
    cmd.width == clru_pkg::WIDTH_WORD && cmd.srcMode &&
    cmd.loc == clru_pkg::LOC_EXTERNAL && cmd.waitN == 4'h2
    |-> ##12 done)
    else $error("external word penalty wrong");

  a_dst_sfr_pen: assert property (@(posedge mclk) disable iff (!reset_n)
    accept && cmd.form == clru_pkg::FORM_SHORT_DIR_ACCUM &&
    cmd.loc == clru_pkg::LOC_PERIPHERAL
    |-> ##1 stateCount == 8'h05)
    else $error("destination peripheral penalty wrong");

  a_cmp_no_write: assert property (@(posedge mclk) disable iff (!reset_n)
    done && st_q.cmd.op == clru_pkg::COMPARE_OP
    |-> !wrEn && result == st_q.cmd.dst &&
        flags.carryFlag == ((st_q.cmd.dst & widthMask(st_q.cmd.width)) <
        (srcOperand(st_q.cmd) & widthMask(st_q.cmd.width))))
    else $error("compare wrote an operand");

  a_word_and_res: assert property (@(posedge mclk) disable iff (!reset_n)
    done && st_q.cmd.op == clru_pkg::BITWISE_AND_OP &&
    st_q.cmd.width == clru_pkg::WIDTH_WORD
    |-> wrEn && result == (st_q.cmd.dst & st_q.cmd.src & 32'h0000FFFF))
    else $error("word and result wrong");

  a_rotl_carry: assert property (@(posedge mclk) disable iff (!reset_n)
    accept && cmd.op == clru_pkg::ROTATE_LEFT_CARRY_OP
    |-> ##2 done && result[7:0] == {$past(cmd.dst[6:0], 2),
        $past(cmd.carryIn, 2)} && flags.carryFlag == $past(cmd.dst[7], 2))
    else $error("rotate left through carry wrong");

  a_rotr_plain: assert property (@(posedge mclk) disable iff (!reset_n)
    done && st_q.cmd.op == clru_pkg::ROTATE_RIGHT_OP
    |-> result[7:0] == {st_q.cmd.dst[0], st_q.cmd.dst[7:1]})
    else $error("rotate right wrong");

  a_clear_accum: assert property (@(posedge mclk) disable iff (!reset_n)
    accept && cmd.op == clru_pkg::CLEAR_ACCUMULATOR_OP &&
    cmd.form == clru_pkg::FORM_ACCUM_ONLY
    |-> ##2 done && result == 32'h00000000 && byteCount == 3'h1)
    else $error("clear accumulator wrong");

  c_compare_done: cover property (@(posedge mclk) disable iff (!reset_n)
    done && st_q.cmd.op == clru_pkg::COMPARE_OP);
  c_ext_access: cover property (@(posedge mclk) disable iff (!reset_n)
    accept && cmd.loc == clru_pkg::LOC_EXTERNAL);
  c_rotate_done: cover property (@(posedge mclk) disable iff (!reset_n)
    done && st_q.cmd.op == clru_pkg::ROTATE_RIGHT_CARRY_OP);
  c_back_to_back: cover property (@(posedge mclk) disable iff (!reset_n)
    done ##1 busy);

endmodule

// [clru_tb.sv]
// self-checking testbench of the compare, logic and rotate unit
`timescale 1ns/10ps
module testbench;
  // ==========================================================
  // one row: a command beside the answer it should give
  typedef struct packed {
    clru_pkg::clru_cmd_t c;
    logic [7:0] s;
    logic [2:0] b;
    logic [31:0] res;
    logic [2:0] fl;
    logic wr;
  } clru_row_t;

  logic mclk;
  logic reset_n;
  logic start;
  clru_pkg::clru_cmd_t cmd;
  logic busy;
  logic done;
  logic wrEn;
  logic [31:0] result;
  clru_pkg::clru_flags_t flags;
  logic [7:0] stateCount;
  logic [2:0] byteCount;
  clru_row_t rows[$];
  int err_total;
  int n_tests;

  clru_unit uut (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(start),
    .cmd(cmd),
    .busy(busy),
    .done(done),
    .wrEn(wrEn),
    .result(result),
    .flags(flags),
    .stateCount(stateCount),
    .byteCount(byteCount)
  );

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // ==========================================================
  // compares and closing
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_zero;
    chk_bit(busy, 1'h0);
    chk_bit(done, 1'h0);
    chk_bit(wrEn, 1'h0);
    chk_val(result, 32'h0);
    chk_val(flags, 32'h0);
    chk_val(stateCount, 32'h0);
    chk_val(byteCount, 32'h0);
  endtask

  // ==========================================================
  // row building; md bit 0 is source mode, bit 1 is ones extension
  function automatic clru_row_t mk(input logic [3:0] op,
      input logic [3:0] fm, input logic [1:0] w, input logic [1:0] md,
      input logic [1:0] loc, input logic [3:0] n, input logic cin,
      input logic [31:0] d, input logic [31:0] sr, input logic [7:0] s,
      input logic [2:0] b, input logic [31:0] res, input logic [2:0] fl,
      input logic wr);
    clru_row_t x;
    x.c.op = clru_pkg::clru_op_t'(op);
    x.c.form = clru_pkg::clru_form_t'(fm);
    x.c.width = clru_pkg::clru_width_t'(w);
    x.c.srcMode = md[0];
    x.c.onesExt = md[1];
    x.c.loc = clru_pkg::clru_loc_t'(loc);
    x.c.waitN = n;
    x.c.carryIn = cin;
    x.c.dst = d;
    x.c.src = sr;
    x.s = s;
    x.b = b;
    x.res = res;
    x.fl = fl;
    x.wr = wr;
    return x;
  endfunction

  task automatic add(input logic [3:0] op, input logic [3:0] fm,
      input logic [1:0] w, input logic [1:0] md, input logic [1:0] loc,
      input logic [3:0] n, input logic cin, input logic [31:0] d,
      input logic [31:0] sr, input logic [7:0] s, input logic [2:0] b,
      input logic [31:0] res, input logic [2:0] fl, input logic wr);
    rows.push_back(mk(op, fm, w, md, loc, n, cin, d, sr, s, b, res, fl, wr));
  endtask

  // ==========================================================
  // one instruction; at cycle poke a refused start with alt is offered
  task automatic run(input clru_row_t x, input logic full, input int poke,
      input clru_pkg::clru_cmd_t alt);
    int n;
    @(negedge mclk);
    start = 1'h1;
    cmd = x.c;
    @(negedge mclk);
    start = 1'h0;
    chk_val(stateCount, x.s);
    chk_val(byteCount, x.b);
    chk_bit(busy, 1'h1);
    n = 1;
    while (done !== 1'h1 && n < 400) begin
      if (n == poke) begin
        start = 1'h1;
        cmd = alt;
      end else begin
        start = 1'h0;
      end
      @(negedge mclk);
      n++;
    end
    start = 1'h0;
    if (n >= 400) begin
      err_total++;
      close_out();
    end
    chk_val(n, x.s + 32'h1);
    chk_bit(busy, 1'h0);
    if (full) begin
      chk_val(result, x.res);
      chk_val(flags, x.fl);
      chk_bit(wrEn, x.wr);
      chk_val(stateCount, x.s);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset_n = 1'h0;
    start = 1'h0;
    cmd = '0;
    err_total = 0;
    n_tests = 0;
    add(4'h0, 4'h0, 2'h1, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h1234, 32'h1234, 8'h03, 3'h3, 32'h1234, 3'h2, 1'h0);
    add(4'h0, 4'h0, 2'h1, 2'h1, 2'h0, 4'h0, 1'h0,
      32'h0001, 32'h0002, 8'h02, 3'h2, 32'h0001, 3'h5, 1'h0);
    add(4'h0, 4'h0, 2'h2, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h80000000, 32'h1, 8'h05, 3'h3, 32'h80000000, 3'h0, 1'h0);
    add(4'h0, 4'h1, 2'h2, 2'h0, 2'h0, 4'h0, 1'h0,
      32'hFFFF, 32'hABCDFFFF, 8'h06, 3'h5, 32'hFFFF, 3'h2, 1'h0);
    add(4'h0, 4'h1, 2'h2, 2'h3, 2'h0, 4'h0, 1'h0,
      32'hFFFF1234, 32'h1234, 8'h05, 3'h4, 32'hFFFF1234, 3'h2, 1'h0);
    add(4'h0, 4'h1, 2'h2, 2'h2, 2'h0, 4'h0, 1'h0,
      32'h1234, 32'h1234, 8'h06, 3'h5, 32'h1234, 3'h4, 1'h0);
    add(4'h0, 4'h1, 2'h1, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h0010, 32'h0011, 8'h04, 3'h5, 32'h0010, 3'h5, 1'h0);
    add(4'h0, 4'h1, 2'h1, 2'h1, 2'h0, 4'h0, 1'h0,
      32'h0011, 32'h0010, 8'h03, 3'h4, 32'h0011, 3'h0, 1'h0);
    add(4'h0, 4'h5, 2'h0, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h80, 32'h01, 8'h04, 3'h4, 32'h80, 3'h0, 1'h0);
    add(4'h0, 4'h5, 2'h0, 2'h1, 2'h3, 4'h3, 1'h0,
      32'h01, 32'h01, 8'h08, 3'h3, 32'h01, 3'h2, 1'h0);
    add(4'h0, 4'h3, 2'h1, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h8000, 32'h0, 8'h04, 3'h5, 32'h8000, 3'h1, 1'h0);
    add(4'h0, 4'h3, 2'h1, 2'h1, 2'h3, 4'h2, 1'h0,
      32'h0, 32'h1, 8'h0B, 3'h4, 32'h0, 3'h5, 1'h0);
    add(4'h0, 4'h2, 2'h0, 2'h0, 2'h1, 4'h0, 1'h0,
      32'h07, 32'h07, 8'h04, 3'h4, 32'h07, 3'h2, 1'h0);
    add(4'h0, 4'h2, 2'h0, 2'h1, 2'h2, 4'h0, 1'h0,
      32'h00, 32'h80, 8'h04, 3'h3, 32'h00, 3'h5, 1'h0);
    add(4'h1, 4'h7, 2'h0, 2'h0, 2'h1, 4'h0, 1'h0,
      32'h0F, 32'h3C, 8'h02, 3'h2, 32'h0C, 3'h0, 1'h1);
    add(4'h2, 4'hA, 2'h0, 2'h1, 2'h0, 4'h0, 1'h0,
      32'h10, 32'h01, 8'h02, 3'h2, 32'h11, 3'h0, 1'h1);
    add(4'h2, 4'hA, 2'h0, 2'h0, 2'h1, 4'h0, 1'h0,
      32'h00, 32'h00, 8'h04, 3'h2, 32'h00, 3'h2, 1'h1);
    add(4'h2, 4'hA, 2'h0, 2'h1, 2'h2, 4'h0, 1'h0,
      32'h80, 32'h01, 8'h05, 3'h2, 32'h81, 3'h1, 1'h1);
    add(4'h3, 4'hB, 2'h0, 2'h0, 2'h0, 4'h0, 1'h0,
      32'hFF, 32'h0F, 8'h03, 3'h3, 32'hF0, 3'h1, 1'h1);
    add(4'h3, 4'hB, 2'h0, 2'h1, 2'h2, 4'h0, 1'h1,
      32'hAA, 32'hAA, 8'h06, 3'h3, 32'h00, 3'h6, 1'h1);
    add(4'h1, 4'h0, 2'h1, 2'h0, 2'h0, 4'h0, 1'h1,
      32'hF0F0, 32'h8F0F, 8'h03, 3'h3, 32'h8000, 3'h5, 1'h1);
    add(4'h3, 4'h0, 2'h1, 2'h1, 2'h0, 4'h0, 1'h0,
      32'h1234, 32'h1234, 8'h02, 3'h2, 32'h0, 3'h2, 1'h1);
    add(4'h3, 4'h1, 2'h1, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h00FF, 32'hFFFF, 8'h04, 3'h5, 32'hFF00, 3'h1, 1'h1);
    add(4'h1, 4'h1, 2'h1, 2'h1, 2'h0, 4'h0, 1'h0,
      32'hFFFF, 32'h0001, 8'h03, 3'h4, 32'h0001, 3'h0, 1'h1);
    add(4'h2, 4'h8, 2'h0, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h01, 32'h02, 8'h02, 3'h1, 32'h03, 3'h0, 1'h1);
    add(4'h1, 4'h8, 2'h0, 2'h1, 2'h0, 4'h0, 1'h0,
      32'h01, 32'h02, 8'h03, 3'h2, 32'h00, 3'h2, 1'h1);
    add(4'h1, 4'h0, 2'h0, 2'h0, 2'h0, 4'h0, 1'h0,
      32'hFF3C, 32'h0F, 8'h02, 3'h3, 32'h0C, 3'h0, 1'h1);
    add(4'h3, 4'h0, 2'h0, 2'h1, 2'h0, 4'h0, 1'h0,
      32'h80, 32'h00, 8'h01, 3'h2, 32'h80, 3'h1, 1'h1);
    add(4'h2, 4'h5, 2'h0, 2'h1, 2'h3, 4'h0, 1'h0,
      32'h40, 32'h02, 8'h05, 3'h3, 32'h42, 3'h0, 1'h1);
    add(4'h4, 4'hC, 2'h0, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h1234FF5A, 32'h0, 8'h01, 3'h1, 32'h0, 3'h2, 1'h1);
    add(4'h5, 4'hC, 2'h0, 2'h1, 2'h0, 4'h0, 1'h0,
      32'hFFFFFF5A, 32'h0, 8'h01, 3'h1, 32'hA5, 3'h1, 1'h1);
    add(4'h6, 4'hC, 2'h0, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h81, 32'h0, 8'h01, 3'h1, 32'h03, 3'h0, 1'h1);
    add(4'h7, 4'hC, 2'h0, 2'h1, 2'h0, 4'h0, 1'h0,
      32'h81, 32'h0, 8'h01, 3'h1, 32'h02, 3'h4, 1'h1);
    add(4'h8, 4'hC, 2'h0, 2'h0, 2'h0, 4'h0, 1'h0,
      32'h81, 32'h0, 8'h01, 3'h1, 32'hC0, 3'h1, 1'h1);
    add(4'h9, 4'hC, 2'h0, 2'h0, 2'h0, 4'h0, 1'h1,
      32'h02, 32'h0, 8'h01, 3'h1, 32'h81, 3'h1, 1'h1);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk_zero();
    reset_n = 1'h1;
    // one after another: each start comes one cycle after the done cycle of the one before
    foreach (rows[i]) begin
      run(rows[i], 1'h1, 0, '0);
    end
    // a start offered while busy must not disturb the running compare
    run(rows[11], 1'h1, 4, rows[31].c);
    // reset in mid instruction clears everything at once
    @(negedge mclk);
    start = 1'h1;
    cmd = rows[11].c;
    @(negedge mclk);
    start = 1'h0;
    repeat (2) @(negedge mclk);
    reset_n = 1'h0;
    #1;
    chk_zero();
    repeat (2) @(negedge mclk);
    reset_n = 1'h1;
    @(negedge mclk);
    chk_zero();
    run(rows[2], 1'h1, 0, '0);
    // unlisted form and width pair costs one state and no bytes
    run(mk(4'h0, 4'hC, 2'h2, 2'h0, 2'h0, 4'h0, 1'h0, 32'h0, 32'h0,
      8'h01, 3'h0, 32'h0, 3'h0, 1'h0), 1'h0, 0, '0);
    close_out();
  end
endmodule
